// *** core/cldc_alu.v ***
// Logic unit: AND and invert with flag results
`timescale 1ns/1ps
`default_nettype none
`include "cldc_consts.vh"
module cldc_alu (
  // Operation
  input wire invert,
  input wire [1:0] size,
  input wire [31:0] dst_val,
  input wire [31:0] src_val,
  input wire [7:0] flags_in,
  // Result
  output reg [31:0] result,
  output reg [7:0] flags_out
);
  function [31:0] cut;
    input [31:0] v;
    input [1:0] sz;
    begin
      case (sz)
        `CLDC_SZ_B: cut = {24'h000000, v[7:0]};
        `CLDC_SZ_W: cut = {16'h0000, v[15:0]};
        default: cut = v;
      endcase
    end
  endfunction
  function msb;
    input [31:0] v;
    input [1:0] sz;
    begin
      case (sz)
        `CLDC_SZ_B: msb = v[7];
        `CLDC_SZ_W: msb = v[15];
        default: msb = v[31];
      endcase
    end
  endfunction
  always @* begin
    flags_out = flags_in;
    if (invert) begin
      result = cut(~dst_val, size);
      flags_out[`CLDC_FL_C] = 1'b0;
      flags_out[`CLDC_FL_B] = (cut(dst_val, size) == 32'h0000_0000);
    end else begin
      result = cut(dst_val & src_val, size);
      flags_out[`CLDC_FL_B] = (cut(dst_val, size) == 32'h0000_0000) ||
                              (cut(src_val, size) == 32'h0000_0000);
    end
    flags_out[`CLDC_FL_V] = 1'b0;
    flags_out[`CLDC_FL_Z] = (result == 32'h0000_0000);
    flags_out[`CLDC_FL_S] = msb(result, size);
  end
endmodule // cldc_alu
`default_nettype wire

// *** core/cldc_consts.vh ***
// Constants for the logic/call/clear decode block
`ifndef CLDC_CONSTS_VH
`define CLDC_CONSTS_VH
`define CLDC_OP_TRAP 16'h0000
`define CLDC_OP_ATOM 16'h0004
`define CLDC_OP_ABSOLUTE_CALL_OP 16'hF231
`define CLDC_HI12_ANDI32 12'hAAA
`define CLDC_HI12_ANDU16 12'hAA2
`define CLDC_HI8_ANDRR 8'hA2
`define CLDC_HI8_ANDDIR 8'h72
`define CLDC_HI8_ANDIDX 8'h7A
`define CLDC_HI12_IMM8 12'hAD9
`define CLDC_HI12_IND16 12'hAB2
`define CLDC_HI12_INDS16 12'hAD2
`define CLDC_HI12_IND32 12'hABA
`define CLDC_HI12_CALLR 12'hF21
`define CLDC_HI4_CALL12 4'hD
`define CLDC_HI8_CALL24 8'hF1
`define CLDC_HI12_CLRD16 12'hADA
`define CLDC_HI12_CLRD32 12'hADB
`define CLDC_HI12_CLRIDX 12'hADC
`define CLDC_HI8_CLRIND 8'hAC
`define CLDC_HI12_INV 12'h454
`define CLDC_IMM8_AND 3'h2
`define CLDC_ATOM_COUNT 2'h3
`define CLDC_SP_STEP 32'h0000_0004
`define CLDC_SP_IDX 4'hF
`define CLDC_SZ_B 2'h0
`define CLDC_SZ_W 2'h1
`define CLDC_SZ_L 2'h2
`define CLDC_FL_C 7
`define CLDC_FL_Z 6
`define CLDC_FL_S 5
`define CLDC_FL_V 4
`define CLDC_FL_B 3
`endif

// *** core/cldc_core.v ***
// Decode and execute of AND, atomic, trap, call, clear and invert
`timescale 1ns/1ps
`default_nettype none
`include "cldc_consts.vh"
module cldc_core (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Memory bus, request held until acknowledge
  output reg mem_req,
  output reg mem_we,
  output reg [1:0] mem_size,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  // Control and status
  input wire debug_break_enable,
  input wire irq_request,
  input wire dma_request,
  output wire irq_accept,
  output wire dma_grant,
  output reg debug_trap_op,
  output reg illegal_opcode_exception,
  output reg instr_done,
  output reg [31:0] pc,
  output reg [7:0] flags,
  output reg [3:0] dbg_reg_sel,
  output wire [31:0] dbg_reg_val
);
  localparam ST_FETCH = 3'h0;
  localparam ST_EXT = 3'h1;
  localparam ST_EXEC = 3'h2;
  localparam ST_READ = 3'h3;
  localparam ST_WRITE = 3'h4;
  localparam ST_HALT = 3'h5;
  localparam K_NONE = 4'h0;
  localparam K_ANDR = 4'h1;
  localparam K_ANDM = 4'h2;
  localparam K_CALL = 4'h3;
  localparam K_CLRM = 4'h4;
  localparam K_INV = 4'h5;
  localparam K_ATOM = 4'h6;
  localparam K_TRAP = 4'h7;
  localparam K_ILL = 4'h8;

  reg [31:0] regs_r [0:15];
  reg [2:0] st_r;
  reg [15:0] w0_r;
  reg [15:0] w1_r;
  // Last extension word, latched since read data only stands with the acknowledge
  reg [15:0] w2_r;
  reg [1:0] need_r;
  reg [1:0] got_r;
  reg [31:0] ea_r;
  reg [31:0] mdat_r;
  reg [1:0] atom_r;
  reg [3:0] kind;
  reg [1:0] size;
  reg sext;
  reg [1:0] nwords;
  reg [31:0] src_val;
  reg [31:0] dst_val;
  reg [31:0] ea;
  reg [31:0] target;
  reg mem_dst;
  wire [3:0] fa = w0_r[7:4];
  wire [3:0] fb = w0_r[3:0];
  wire [31:0] imm32 = {w1_r, w2_r};
  wire [31:0] alu_res;
  wire [7:0] alu_flags;

  assign dbg_reg_val = regs_r[dbg_reg_sel];
  assign irq_accept = irq_request && (atom_r == 2'h0) && (st_r == ST_FETCH);
  assign dma_grant = dma_request && (atom_r == 2'h0) && (st_r == ST_FETCH);

  function [31:0] ext;
    input [31:0] v;
    input [1:0] sz;
    input sg;
    begin
      case (sz)
        `CLDC_SZ_B: ext = sg ? {{24{v[7]}}, v[7:0]} : {24'h000000, v[7:0]};
        `CLDC_SZ_W: ext = sg ? {{16{v[15]}}, v[15:0]} : {16'h0000, v[15:0]};
        default: ext = v;
      endcase
    end
  endfunction

  // Extension word count per opcode, from word0 alone
  function [1:0] ext_words;
    input [15:0] w;
    begin
      ext_words = 2'h0;
      if (w[15:4] == `CLDC_HI12_ANDI32 || w[15:4] == `CLDC_HI12_IND32 ||
          w == `CLDC_OP_ABSOLUTE_CALL_OP || w[15:4] == `CLDC_HI12_CLRD32)
        ext_words = 2'h2;
      else if (w[15:8] == `CLDC_HI8_ANDDIR)
        ext_words = w[7] ? 2'h2 : 2'h1;
      else if (w[15:4] == `CLDC_HI12_ANDU16 || w[15:8] == `CLDC_HI8_ANDIDX ||
               w[15:4] == `CLDC_HI12_IMM8 || w[15:4] == `CLDC_HI12_IND16 ||
               w[15:4] == `CLDC_HI12_INDS16 || w[15:8] == `CLDC_HI8_CALL24 ||
               w[15:4] == `CLDC_HI12_CLRD16 || w[15:4] == `CLDC_HI12_CLRIDX)
        ext_words = 2'h1;
    end
  endfunction

  // Decode of the fully fetched instruction
  always @* begin
    kind = K_ILL;
    size = `CLDC_SZ_L;
    sext = 1'b0;
    src_val = 32'h0000_0000;
    dst_val = regs_r[fb];
    ea = 32'h0000_0000;
    target = 32'h0000_0000;
    mem_dst = 1'b0;
    if (w0_r == `CLDC_OP_TRAP) begin
      kind = debug_break_enable ? K_TRAP : K_ILL;
    end else if (w0_r == `CLDC_OP_ATOM) begin
      kind = K_ATOM;
    end else if (w0_r == `CLDC_OP_ABSOLUTE_CALL_OP) begin
      kind = K_CALL;
      target = {imm32[31:1], 1'b0};
    end else if (w0_r[15:4] == `CLDC_HI12_ANDI32) begin
      kind = K_ANDR;
      src_val = imm32;
    end else if (w0_r[15:4] == `CLDC_HI12_ANDU16) begin
      kind = K_ANDR;
      src_val = {16'h0000, w2_r};
    end else if (w0_r[15:8] == `CLDC_HI8_ANDRR) begin
      kind = K_ANDR;
      src_val = regs_r[fa];
    end else if (w0_r[15:8] == `CLDC_HI8_ANDDIR) begin
      kind = K_ANDM;
      ea = w0_r[7] ? imm32 : {{16{w2_r[15]}}, w2_r};
      mem_dst = w0_r[6:4] == 3'h7 || w0_r[6:4] == 3'h6 || w0_r[6:4] == 3'h5;
      case (w0_r[6:4])
        3'h0, 3'h1, 3'h5: size = `CLDC_SZ_B;
        3'h2, 3'h3, 3'h6: size = `CLDC_SZ_W;
        default: size = `CLDC_SZ_L;
      endcase
      sext = w0_r[4];
      src_val = regs_r[fb];
    end else if (w0_r[15:8] == `CLDC_HI8_ANDIDX) begin
      kind = K_ANDM;
      mem_dst = w2_r[15:13] == 3'h7 || w2_r[15:13] == 3'h6 || w2_r[15:13] == 3'h5;
      case (w2_r[15:13])
        3'h0, 3'h1, 3'h5: size = `CLDC_SZ_B;
        3'h2, 3'h3, 3'h6: size = `CLDC_SZ_W;
        default: size = `CLDC_SZ_L;
      endcase
      sext = w2_r[13];
      if (!mem_dst)
        ea = regs_r[fa] + {{19{w2_r[12]}}, w2_r[12:0]};
      else
        ea = regs_r[fb] + {{19{w2_r[12]}}, w2_r[12:0]};
      src_val = mem_dst ? regs_r[fa] : regs_r[fb];
    end else if (w0_r[15:4] == `CLDC_HI12_IMM8) begin
      kind = (w2_r[10:8] == `CLDC_IMM8_AND) ? K_ANDM : K_ILL;
      mem_dst = 1'b1;
      size = `CLDC_SZ_B;
      ea = regs_r[fb];
      src_val = {24'h000000, w2_r[7:0]};
    end else if (w0_r[15:4] == `CLDC_HI12_IND16 || w0_r[15:4] == `CLDC_HI12_INDS16 ||
                 w0_r[15:4] == `CLDC_HI12_IND32) begin
      kind = K_ANDM;
      mem_dst = 1'b1;
      ea = regs_r[fb];
      size = (w0_r[15:4] == `CLDC_HI12_IND16) ? `CLDC_SZ_W : `CLDC_SZ_L;
      src_val = (w0_r[15:4] == `CLDC_HI12_IND32) ? imm32 :
                (w0_r[15:4] == `CLDC_HI12_INDS16) ? {{16{w2_r[15]}}, w2_r} :
                {16'h0000, w2_r};
    end else if (w0_r[15:4] == `CLDC_HI12_CALLR) begin
      kind = K_CALL;
      target = {regs_r[fb][31:1], 1'b0};
    end else if (w0_r[15:12] == `CLDC_HI4_CALL12) begin
      kind = K_CALL;
      target = pc + {{19{w0_r[11]}}, w0_r[11:0], 1'b0};
    end else if (w0_r[15:8] == `CLDC_HI8_CALL24) begin
      kind = K_CALL;
      target = pc + {{7{w0_r[7]}}, w0_r[7:0], w2_r, 1'b0};
    end else if (w0_r[15:4] == `CLDC_HI12_CLRD16 || w0_r[15:4] == `CLDC_HI12_CLRD32) begin
      kind = K_CLRM;
      ea = w0_r[4] ? imm32 : {{16{w2_r[15]}}, w2_r};
      size = w0_r[3] ? `CLDC_SZ_L : w0_r[2] ? `CLDC_SZ_W : `CLDC_SZ_B;
      if (w0_r[1:0] != 2'h0)
        kind = K_ILL;
    end else if (w0_r[15:4] == `CLDC_HI12_CLRIDX) begin
      kind = K_CLRM;
      ea = regs_r[fb] + {{18{w2_r[13]}}, w2_r[13:0]};
      size = w2_r[15] ? `CLDC_SZ_L : w2_r[14] ? `CLDC_SZ_W : `CLDC_SZ_B;
    end else if (w0_r[15:8] == `CLDC_HI8_CLRIND && w0_r[5:4] == 2'h0) begin
      kind = K_CLRM;
      ea = regs_r[fb];
      size = w0_r[7] ? `CLDC_SZ_L : w0_r[6] ? `CLDC_SZ_W : `CLDC_SZ_B;
    end else if (w0_r[15:4] == `CLDC_HI12_INV) begin
      kind = K_INV;
    end
  end

  // Memory operand arrives in mdat_r for the ST_WRITE write-back
  cldc_alu u_alu (
    .invert(kind == K_INV),
    .size((kind == K_ANDM) && mem_dst ? size : `CLDC_SZ_L),
    .dst_val((kind == K_ANDM) ? (mem_dst ? mdat_r : dst_val) : dst_val),
    .src_val((kind == K_ANDM) ? (mem_dst ? src_val : ext(mdat_r, size, sext)) : src_val),
    .flags_in(flags),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_FETCH;
      pc <= 32'h0000_0000;
      flags <= 8'h00;
      w0_r <= 16'h0000;
      w1_r <= 16'h0000;
      w2_r <= 16'h0000;
      need_r <= 2'h0;
      got_r <= 2'h0;
      ea_r <= 32'h0000_0000;
      mdat_r <= 32'h0000_0000;
      atom_r <= 2'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_size <= `CLDC_SZ_W;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      debug_trap_op <= 1'b0;
      illegal_opcode_exception <= 1'b0;
      instr_done <= 1'b0;
      dbg_reg_sel <= 4'h0;
    end else begin
      debug_trap_op <= 1'b0;
      illegal_opcode_exception <= 1'b0;
      instr_done <= 1'b0;
      case (st_r)
        ST_FETCH: begin
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          mem_size <= `CLDC_SZ_W;
          mem_addr <= pc;
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            w0_r <= mem_rdata[15:0];
            pc <= pc + 32'h0000_0002;
            need_r <= ext_words(mem_rdata[15:0]);
            got_r <= 2'h0;
            st_r <= (ext_words(mem_rdata[15:0]) == 2'h0) ? ST_EXEC : ST_EXT;
          end
        end
        ST_EXT: begin
          mem_req <= 1'b1;
          mem_addr <= pc;
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            pc <= pc + 32'h0000_0002;
            got_r <= got_r + 2'h1;
            if (got_r + 2'h1 == need_r) begin
              st_r <= ST_EXEC;
              w2_r <= mem_rdata[15:0];
            end else begin
              w1_r <= mem_rdata[15:0]; // Upper half first
            end
          end
        end
        ST_EXEC: begin
          // Latch the decoded address for ST_WRITE; the memory operand is read later, in ST_READ
          ea_r <= ea;
          st_r <= ST_FETCH;
          if (kind != K_ATOM && kind != K_TRAP && kind != K_ILL && atom_r != 2'h0)
            atom_r <= atom_r - 2'h1;
          case (kind)
            K_ANDR: begin
              regs_r[fb] <= alu_res;
              flags <= alu_flags;
              instr_done <= 1'b1;
            end
            K_ANDM: begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_size <= size;
              mem_addr <= ea;
              st_r <= ST_READ;
            end
            K_CALL: begin
              regs_r[`CLDC_SP_IDX] <= regs_r[`CLDC_SP_IDX] - `CLDC_SP_STEP;
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_size <= `CLDC_SZ_L;
              mem_addr <= regs_r[`CLDC_SP_IDX] - `CLDC_SP_STEP;
              mem_wdata <= pc;
              ea_r <= target;
              st_r <= ST_WRITE;
            end
            K_CLRM: begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_size <= size;
              mem_addr <= ea;
              mem_wdata <= 32'h0000_0000;
              st_r <= ST_WRITE;
            end
            K_INV: begin
              regs_r[fb] <= alu_res;
              flags <= alu_flags;
              instr_done <= 1'b1;
            end
            K_ATOM: begin
              atom_r <= `CLDC_ATOM_COUNT;
              instr_done <= 1'b1;
            end
            K_TRAP: begin
              debug_trap_op <= 1'b1;
              pc <= pc - 32'h0000_0002;
              st_r <= ST_HALT;
            end
            default: begin
              illegal_opcode_exception <= 1'b1;
              st_r <= ST_HALT;
            end
          endcase
        end
        ST_READ: begin
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            mdat_r <= mem_rdata;
            st_r <= ST_WRITE;
            mem_we <= 1'b0;
          end
        end
        ST_WRITE: begin
          if (kind == K_ANDM && !mem_we && !mem_req) begin
            flags <= alu_flags;
            if (mem_dst) begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_addr <= ea_r;
              mem_wdata <= alu_res;
            end else begin
              regs_r[fb] <= alu_res;
              instr_done <= 1'b1;
              st_r <= ST_FETCH;
            end
          end else if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            instr_done <= 1'b1;
            if (kind == K_CALL)
              pc <= ea_r;
            st_r <= ST_FETCH;
          end
        end
        ST_HALT: begin
          // Waits for reset; trap handling lies outside this block
          st_r <= ST_HALT;
        end
        default: st_r <= ST_FETCH;
      endcase
    end
  end
endmodule // cldc_core
`default_nettype wire

// *** testbench/cldc_core_properties.sv ***
// Port-level assertions for the decode core
`timescale 1ns/1ps
`default_nettype none
module cldc_core_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Memory bus
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Control and status
  input wire logic debug_break_enable,
  input wire logic irq_request,
  input wire logic dma_request,
  input wire logic irq_accept,
  input wire logic dma_grant,
  input wire logic debug_trap_op,
  input wire logic illegal_opcode_exception,
  input wire logic instr_done,
  input wire logic [7:0] flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic w0_r, pend_r, call_r, clr_r, inv_r, trap_r;
  logic [1:0] atom_r;
  wire [15:0] w = mem_rdata[15:0];
  wire take0 = w0_r && mem_req && mem_ack;
  wire keep = trap_r || pend_r || call_r || clr_r;
  // Opcode class of the instruction in flight, latched from its first word
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {w0_r, pend_r, call_r, clr_r, inv_r, trap_r, atom_r} <= 8'h80;
    end else begin
      if (take0) begin
        w0_r <= 1'b0;
        trap_r <= w == 16'h0000;
        pend_r <= w == 16'h0004;
        call_r <= w[15:4] == 12'hF21 || w[15:12] == 4'hD || w[15:8] == 8'hF1 || w == 16'hF231;
        clr_r <= w[15:4] == 12'hADA || w[15:4] == 12'hADB || w[15:4] == 12'hADC || w[15:8] == 8'hAC;
        inv_r <= w[15:4] == 12'h454;
      end
      if (instr_done) begin
        w0_r <= 1'b1;
        {pend_r, call_r, clr_r, inv_r} <= 4'h0;
        atom_r <= pend_r ? 2'h3 : atom_r - {1'b0, atom_r != 2'h0};
      end
    end
  end
  sequence s_halted;
    (!mem_req && !instr_done) [*4];
  endsequence
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_size, mem_addr, mem_wdata}))
    else $error("bus request changed before acknowledge");
  AST_ATOM_BLOCK: assert property ((atom_r > 2'h1) || (atom_r == 2'h1 && !instr_done) |-> !irq_accept && !dma_grant)
    else $error("request accepted inside atomic group");
  AST_ACCEPT_REQ: assert property ((irq_accept |-> irq_request) and (dma_grant |-> dma_request))
    else $error("accept without request");
  AST_FLAGS_KEEP: assert property (keep |=> $stable(flags))
    else $error("flags changed by flag-neutral instruction");
  AST_PUSH_LONG: assert property (call_r && mem_req && mem_we |-> mem_size == 2'h2)
    else $error("call push not 32 bits");
  AST_CLR_ZERO: assert property (clr_r && mem_req && mem_we |-> (mem_size == 2'h0 ? mem_wdata[7:0] == 8'h00 :
    mem_size == 2'h1 ? mem_wdata[15:0] == 16'h0000 : mem_wdata == 32'h0000_0000))
    else $error("clear wrote nonzero data");
  AST_INV_FLAGS: assert property (instr_done && inv_r |-> !flags[7] && !flags[4])
    else $error("invert left carry or overflow set");
  AST_IE_KEEP: assert property ($stable(flags[1:0]))
    else $error("interrupt enable flags changed");
  AST_TRAP_SEL: assert property (debug_trap_op |-> trap_r && $past(debug_break_enable))
    else $error("break taken while disabled");
  AST_ILL_SEL: assert property (trap_r && illegal_opcode_exception |-> !$past(debug_break_enable))
    else $error("illegal taken while break enabled");
  AST_HALT: assert property (debug_trap_op || illegal_opcode_exception |=> s_halted)
    else $error("core ran on after break or illegal");
endmodule // cldc_core_properties
`default_nettype wire

// *** testbench/cldc_mem_model.sv ***
// Big-endian memory answering the core's request/acknowledge bus
`timescale 1ns/1ps
`default_nettype none
module cldc_mem_model (
  // Clock
  input wire logic core_clk,
  // Bus from the core
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Answer delay
  input wire logic [3:0] wait_cycles
);
  logic [7:0] mem [logic [31:0]];
  logic [3:0] cnt;
  logic [31:0] last;
  function automatic logic [7:0] b(input logic [31:0] a);
    b = mem.exists(a) ? mem[a] : 8'h00;
  endfunction
  function automatic logic [31:0] peek(input logic [31:0] a, input logic [1:0] s);
    peek = s == 2'h0 ? {24'h0, b(a)} : s == 2'h1 ? {16'h0, b(a), b(a + 1)} : {b(a), b(a + 1), b(a + 2), b(a + 3)};
  endfunction
  initial begin
    mem_ack = 1'b0;
    cnt = 4'h0;
    last = 32'h0;
  end
  // Outside the ack cycle the bus shows inverted data, so stale reads never match
  assign mem_rdata = mem_ack ? last : ~last;
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    if (mem_req && mem_ack && mem_we)
      for (int i = 0; i < (1 << mem_size); i++)
        mem[mem_addr + i] = mem_wdata[8 * ((1 << mem_size) - 1 - i) +: 8];
    if (mem_req && !mem_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= wait_cycles) begin
        mem_ack <= 1'b1;
        last <= peek(mem_addr, mem_size);
        cnt <= 4'h0;
      end
    end
  end
endmodule // cldc_mem_model
`default_nettype wire

// *** testbench/cpu_logic_call_clear_decode_bench.sv ***
// Directed program run against the decode core and memory model
`timescale 1ns/1ps
`default_nettype none
module cpu_logic_call_clear_decode_bench;
  logic core_clk, rst_n, debug_break_enable, irq_request, dma_request, mem_req, mem_we, mem_ack;
  logic irq_accept, dma_grant, debug_trap_op, illegal_opcode_exception, instr_done;
  logic [1:0] mem_size;
  logic [3:0] wait_cycles;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, pc, dbg_reg_val, at;
  logic [7:0] flags;
  int n_fail, comparisons, acc_n;
  cldc_core cldc_core_i (.core_clk, .rst_n, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .debug_break_enable, .irq_request, .dma_request, .irq_accept, .dma_grant, .debug_trap_op,
    .illegal_opcode_exception, .instr_done, .pc, .flags, .dbg_reg_sel(), .dbg_reg_val);
  cldc_mem_model cldc_mem_model_i (.core_clk, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .wait_cycles);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) acc_n <= acc_n + (irq_accept === 1'b1 && dma_grant === 1'b1);
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [15:0] ws[$]);
    foreach (ws[i]) begin
      cldc_mem_model_i.mem[at] = ws[i][15:8];
      cldc_mem_model_i.mem[at + 1] = ws[i][7:0];
      at += 2;
    end
  endtask
  // Counts completions, breaks and illegal pulses alike
  task automatic step(input int n);
    int t;
    t = 0;
    while (n > 0 && t < 400) begin
      @(posedge core_clk);
      #1;
      t++;
      if ((instr_done | debug_trap_op | illegal_opcode_exception) === 1'b1) n--;
    end
    if (n > 0) begin
      chk("completion wait", 0, n);
      finish_test();
    end
  endtask
  task automatic ex(input int n, input logic [31:0] r, input logic [7:0] f);
    step(n);
    chk("r0", r, dbg_reg_val);
    chk("flags", {24'h0, f}, {24'h0, flags});
  endtask
  task automatic reset_core;
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  initial begin
    rst_n = 1'b0;
    debug_break_enable = 1'b0;
    irq_request = 1'b1;
    dma_request = 1'b1;
    wait_cycles = 4'h0;
    acc_n = 0;
    // Registers start unknown; no register-clear opcode, so AND with zero memory
    at = 32'h0;
    put('{16'h7240, 16'h1000, 16'h4540, 16'hAAA0, 16'h7F37, 16'hB2D3, 16'h4540, 16'h7210, 16'h1004});
    put('{16'h7200, 16'h1004, 16'hAA20, 16'h8008, 16'hA200, 16'h724F, 16'h1000, 16'h454F, 16'hAAAF});
    put('{16'h0000, 16'h2000, 16'h0004, 16'h7A00, 16'h8FF8, 16'hA200, 16'hA200, 16'hD005});
    at = 32'h3E;
    put('{16'hF231, 16'h0000, 16'h3001});
    at = 32'h3000;
    put('{16'h4540, 16'hAA20, 16'h4001, 16'hF210});
    at = 32'h4000;
    put('{16'hADA8, 16'h1008, 16'hADA0, 16'h100C, 16'hADA4, 16'h100E, 16'hADB0, 16'h0000, 16'h1010});
    put('{16'hADC0, 16'h4100, 16'h0000});
    at = 32'h1004;
    put('{16'hEA00, 16'h0000, 16'h8BF7, 16'h47AF, 16'hFC11, 16'hFFFF, 16'h5555});
    at = 32'h4100;
    put('{16'hAAAA, 16'hAAAA});
    reset_core();
    ex(1, 32'h0, 8'h48);
    ex(1, 32'hFFFF_FFFF, 8'h28);
    ex(1, 32'h7F37_B2D3, 8'h00);
    ex(1, 32'h80C8_4D2C, 8'h20);
    ex(1, 32'h80C8_4D28, 8'h20);
    ex(1, 32'h0000_0028, 8'h00);
    ex(1, 32'h0000_0008, 8'h00);
    ex(1, 32'h0000_0008, 8'h00);
    step(3);
    @(posedge core_clk);
    wait_cycles <= 4'h2;
    ex(1, 32'h0000_0008, 8'h00);
    acc_n = 0;
    ex(3, 32'h0, 8'h48);
    chk("accept in group", 0, acc_n);
    ex(1, 32'h0, 8'h48);
    chk("pc relative_offset_short", 32'h3E, pc);
    chk("push relative_offset_short", 32'h34, cldc_mem_model_i.peek(32'h1FFC, 2'h2));
    chk("accept after group", 1, acc_n != 0);
    step(1);
    chk("pc abs", 32'h3000, pc);
    chk("push abs", 32'h44, cldc_mem_model_i.peek(32'h1FF8, 2'h2));
    step(3);
    chk("pc reg", 32'h4000, pc);
    chk("r0 kept", 32'h4001, dbg_reg_val);
    chk("push reg", 32'h3008, cldc_mem_model_i.peek(32'h1FF4, 2'h2));
    ex(5, 32'h4001, 8'h00);
    chk("clr long", 32'h0, cldc_mem_model_i.peek(32'h1008, 2'h2));
    chk("clr byte word", 32'h0011_0000, cldc_mem_model_i.peek(32'h100C, 2'h2));
    chk("clr addr32", 32'h0055_0000, cldc_mem_model_i.peek(32'h1010, 2'h2));
    chk("clr indexed", 32'hAA00_00AA, cldc_mem_model_i.peek(32'h4100, 2'h2));
    step(1);
    chk("illegal", 1, illegal_opcode_exception);
    chk("no break", 0, debug_trap_op);
    debug_break_enable <= 1'b1;
    wait_cycles <= 4'h3;
    at = 32'h0;
    put('{16'h0000});
    reset_core();
    step(1);
    chk("break", 1, debug_trap_op);
    chk("pc break", 32'h0, pc);
    chk("flags break", 32'h0, {24'h0, flags});
    finish_test();
  end
endmodule // cpu_logic_call_clear_decode_bench
bind cldc_core cldc_core_properties cldc_core_properties_i (.core_clk, .rst_n, .mem_req, .mem_we, .mem_size,
  .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .debug_break_enable, .irq_request, .dma_request, .irq_accept,
  .dma_grant, .debug_trap_op, .illegal_opcode_exception, .instr_done, .flags);
`default_nettype wire
